// file: design/qhp_pkg.sv
// Shared constants for the quad UART host bus port controller
package qhp_pkg;

  // ----------------------------------------------------------------
  // Clock and pin timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int SETUP_NS = 20;
  localparam int STROBE_NS = 50;
  localparam int HOLD_NS = 20;
  // Least times round up to whole cycles, never below one
  localparam int SETUP_CYC = ((SETUP_NS * CLK_MHZ + 999) / 1000) < 1 ? 1 : ((SETUP_NS * CLK_MHZ + 999) / 1000);
  localparam int STROBE_CYC = ((STROBE_NS * CLK_MHZ + 999) / 1000) < 1 ? 1 : ((STROBE_NS * CLK_MHZ + 999) / 1000);
  localparam int HOLD_CYC = ((HOLD_NS * CLK_MHZ + 999) / 1000) < 1 ? 1 : ((HOLD_NS * CLK_MHZ + 999) / 1000);
  localparam int CNT_W = 8;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CMD = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RDATA = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_EVENT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h14;

  // CTRL fields
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_FORCE_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // CMD fields
  localparam int CMD_WDATA_LSB = 0;
  localparam int CMD_REG_LSB = 8;
  localparam int CMD_CHAN_LSB = 11;
  localparam int CMD_READ_BIT = 16;

  // STATUS fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_TX_READY_N_BIT = 1;
  localparam int ST_RX_READY_N_BIT = 2;
  localparam int ST_MODE_BIT = 3;
  localparam int ST_IRQ_LSB = 4;

  // EVENT and MASK fields
  localparam int EV_W = 7;
  localparam int EV_DONE_BIT = 0;
  localparam int EV_IRQ_LSB = 1;
  localparam int EV_TX_READY_N_BIT = 5;
  localparam int EV_RX_READY_N_BIT = 6;

  // Bus style: high selects separate strobes, low the direction line
  localparam logic MODE_RWLINE = 1'b0;
  localparam logic MODE_STROBE = 1'b1;

  localparam int NUM_CHAN = 4;
  localparam int REG_AW = 3;
  localparam int CHAN_W = 2;
  localparam int DATA_W = 8;

  // Pin cycle sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_SETUP = 2'b01,
    SEQ_STROBE = 2'b10,
    SEQ_HOLD = 2'b11
  } qhp_seq_state_e;

endpackage

// file: design/qhp_seq_if.sv
// Handshake between the register front end and the pin cycle sequencer
`timescale 1ns/1ps
interface qhp_seq_if;
  logic start;
  logic busy;
  logic inCycle;
  logic strobeOn;
  logic capture;
  logic done;

  modport ctl (
    output start,
    input busy,
    input inCycle,
    input strobeOn,
    input capture,
    input done
  );

  modport seq (
    input start,
    output busy,
    output inCycle,
    output strobeOn,
    output capture,
    output done
  );
endinterface

// file: design/qhp_pin_sequencer.sv
// Phase sequencer for one device bus cycle: setup, strobe, hold
`timescale 1ns/1ps
module qhp_pin_sequencer
  import qhp_pkg::*;
#(
  parameter int SETUP_N = SETUP_CYC,
  parameter int STROBE_N = STROBE_CYC,
  parameter int HOLD_N = HOLD_CYC
) (
  input wire logic clk,
  input wire logic rst,
  qhp_seq_if.seq cyc
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (SETUP_N < 1 || STROBE_N < 1 || HOLD_N < 1 || SETUP_N >= (1 << CNT_W) || STROBE_N >= (1 << CNT_W)
      || HOLD_N >= (1 << CNT_W)) begin : gBadTiming
    $error("qhp_pin_sequencer: phase counts must be 1 to 255");
  end

  qhp_seq_state_e stateQ;
  qhp_seq_state_e stateD;
  logic [CNT_W-1:0] cntQ;
  logic [CNT_W-1:0] cntD;
  wire cntZero = (cntQ == '0);

  // Phase walk; each phase lasts its count of cycles
  always_comb begin
    stateD = stateQ;
    cntD = cntZero ? cntQ : cntQ - 1'b1;
    case (stateQ)
      SEQ_IDLE: begin
        if (cyc.start) begin
          stateD = SEQ_SETUP;
          cntD = CNT_W'(SETUP_N - 1);
        end
      end
      SEQ_SETUP: begin
        if (cntZero) begin
          stateD = SEQ_STROBE;
          cntD = CNT_W'(STROBE_N - 1);
        end
      end
      SEQ_STROBE: begin
        if (cntZero) begin
          stateD = SEQ_HOLD;
          cntD = CNT_W'(HOLD_N - 1);
        end
      end
      SEQ_HOLD: begin
        if (cntZero) begin
          stateD = SEQ_IDLE;
        end
      end
      default: begin
        stateD = SEQ_IDLE;
        cntD = '0;
      end
    endcase
  end

  // State and counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stateQ <= SEQ_IDLE;
      cntQ <= '0;
    end else begin
      stateQ <= stateD;
      cntQ <= cntD;
    end
  end

  // Pins follow the next phase so they change on the same edge as the state
  assign cyc.inCycle = (stateD != SEQ_IDLE);
  assign cyc.strobeOn = (stateD == SEQ_STROBE);
  assign cyc.capture = (stateQ == SEQ_STROBE) && cntZero;
  assign cyc.done = (stateQ == SEQ_HOLD) && cntZero;
  assign cyc.busy = (stateQ != SEQ_IDLE);

endmodule

// file: design/qhp_irq_status.sv
// Sticky event flags, mask and level interrupt output
`timescale 1ns/1ps
module qhp_irq_status
  import qhp_pkg::*;
#(
  parameter int W = EV_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] evtSet,
  input wire logic [W-1:0] evtClr,
  input wire logic maskWe,
  input wire logic [W-1:0] maskIn,
  output logic [W-1:0] status,
  output logic [W-1:0] mask,
  output logic irq
);

  if (W < 1) begin : gBadWidth
    $error("qhp_irq_status: width must be at least 1");
  end

  logic [W-1:0] statusQ;
  logic [W-1:0] maskQ;
  // Set wins over clear, so an event landing on the clearing read survives
  wire [W-1:0] statusD = (statusQ & ~evtClr) | evtSet;

  // Flags and mask
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      statusQ <= '0;
      maskQ <= '0;
    end else begin
      statusQ <= statusD;
      if (maskWe) begin
        maskQ <= maskIn;
      end
    end
  end

  assign status = statusQ;
  assign mask = maskQ;
  assign irq = |(statusQ & maskQ);

endmodule

// file: design/qhp_host_port.sv
// Host controller driving the parallel bus of a quad UART device
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
// Operation
// - Strobe style: falling read strobe starts a read of register A2:A0.
// - Strobe style: host captures the data byte on the rising read strobe.
// - Direction-line style: host holds the read strobe permanently high.
// - Strobe style: write strobe low then high; data stored on its rising edge.
// - Direction-line style: write strobe pin is direction, high read, low write.
// - Strobe style: only the addressed channel's active-low select goes low.
// - Direction-line style: channel A select is the single device select.
// - Direction-line style: channel B and C selects carry address lines A3, A4.
// - Direction-line style: host ties the channel D select high.
// - Interrupt force input enables outputs in strobe style; held low otherwise.
module qhp_host_port
  import qhp_pkg::*;
#(
  parameter int SETUP_N = qhp_pkg::SETUP_CYC,
  parameter int STROBE_N = qhp_pkg::STROBE_CYC,
  parameter int HOLD_N = qhp_pkg::HOLD_CYC
) (
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic [qhp_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic irq,
  // Device bus pins
  output logic bus_mode_sel,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic chan_a_select_n,
  output logic chan_b_select_n,
  output logic chan_c_select_n,
  output logic chan_d_select_n,
  output logic [qhp_pkg::REG_AW-1:0] reg_addr,
  output logic [qhp_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [qhp_pkg::DATA_W-1:0] data_in,
  output logic irq_force_enable,
  input wire logic chan_a_irq,
  input wire logic chan_b_irq,
  input wire logic chan_c_irq,
  input wire logic chan_d_irq,
  input wire logic tx_ready_n,
  input wire logic rx_ready_n
);
  import qhp_pkg::*;

  // ----------------------------------------------------------------
  // Parameter and layout checks
  // ----------------------------------------------------------------
  // Phase counts must fit the sequencer counter
  if (SETUP_N < 1 || STROBE_N < 1 || HOLD_N < 1 || SETUP_N >= (1 << CNT_W) || STROBE_N >= (1 << CNT_W)
      || HOLD_N >= (1 << CNT_W)) begin : gBadTiming
    $error("qhp_host_port: phase counts must be 1 to 255");
  end
  // Select and interrupt pin mapping is written out for four channels
  if (NUM_CHAN != 4 || CHAN_W != 2) begin : gBadChan
    $error("qhp_host_port: pin mapping serves four channels only");
  end
  // Command fields are packed low to high without overlap
  if (CMD_REG_LSB < CMD_WDATA_LSB + DATA_W || CMD_CHAN_LSB < CMD_REG_LSB + REG_AW
      || CMD_READ_BIT < CMD_CHAN_LSB + CHAN_W || CMD_READ_BIT > 31) begin : gBadCmd
    $error("qhp_host_port: command fields overlap");
  end
  // Status and event words are built by concatenation in a fixed order
  if (ST_TX_READY_N_BIT != ST_BUSY_BIT + 1 || ST_RX_READY_N_BIT != ST_TX_READY_N_BIT + 1 || ST_MODE_BIT != ST_RX_READY_N_BIT + 1
      || ST_IRQ_LSB != ST_MODE_BIT + 1) begin : gBadStatus
    $error("qhp_host_port: status fields out of order");
  end
  if (EV_IRQ_LSB != EV_DONE_BIT + 1 || EV_TX_READY_N_BIT != EV_IRQ_LSB + NUM_CHAN || EV_RX_READY_N_BIT != EV_TX_READY_N_BIT + 1
      || EV_W != EV_RX_READY_N_BIT + 1) begin : gBadEvent
    $error("qhp_host_port: event fields out of order");
  end

  // ----------------------------------------------------------------
  // Sequencer and interrupt block
  // ----------------------------------------------------------------
  qhp_seq_if cyc ();

  qhp_pin_sequencer #(
    .SETUP_N(SETUP_N),
    .STROBE_N(STROBE_N),
    .HOLD_N(HOLD_N)
  ) uSeq (
    .clk(clk),
    .rst(rst),
    .cyc(cyc)
  );

  logic [EV_W-1:0] evtSet;
  logic [EV_W-1:0] evtClr;
  logic [EV_W-1:0] evtStatus;
  logic [EV_W-1:0] evtMask;
  logic maskWe;

  qhp_irq_status #(
    .W(EV_W)
  ) uIrq (
    .clk(clk),
    .rst(rst),
    .evtSet(evtSet),
    .evtClr(evtClr),
    .maskWe(maskWe),
    .maskIn(pwdata[EV_W-1:0]),
    .status(evtStatus),
    .mask(evtMask),
    .irq(irq)
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire setupPh = psel && !penable;
  wire accessPh = psel && penable;
  wire hitCtrl = (paddr == OFS_CTRL);
  wire hitCmd = (paddr == OFS_CMD);
  wire hitStatus = (paddr == OFS_STATUS);
  wire hitRdata = (paddr == OFS_RDATA);
  wire hitEvent = (paddr == OFS_EVENT);
  wire hitMask = (paddr == OFS_MASK);
  wire mapped = hitCtrl | hitCmd | hitStatus | hitRdata | hitEvent | hitMask;
  wire wrAcc = accessPh && pwrite;
  wire rdAcc = accessPh && !pwrite;

  // Zero wait states: every access completes in its first access cycle
  assign pready = accessPh;
  assign pslverr = accessPh && !mapped;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic modeQ;
  logic forceQ;
  logic startQ;
  logic readQ;
  logic [CHAN_W-1:0] chanQ;
  logic [REG_AW-1:0] regQ;
  logic [DATA_W-1:0] wdataQ;
  logic [DATA_W-1:0] rdataQ;
  logic [31:0] prdataQ;
  logic [EV_W-1:0] rdSnapQ;

  // A command is refused while a cycle runs; mode is frozen too
  wire busyAll = cyc.busy | startQ;
  wire cmdTake = wrAcc && hitCmd && !busyAll;
  wire ctrlTake = wrAcc && hitCtrl;
  assign maskWe = wrAcc && hitMask;

  // Control and command capture
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      modeQ <= MODE_RWLINE;
      forceQ <= 1'b0;
      startQ <= 1'b0;
      readQ <= 1'b0;
      chanQ <= '0;
      regQ <= '0;
      wdataQ <= '0;
    end else begin
      startQ <= cmdTake;
      if (ctrlTake && !busyAll) begin
        modeQ <= pwdata[CTRL_MODE_BIT];
      end
      if (ctrlTake) begin
        forceQ <= pwdata[CTRL_FORCE_BIT];
      end
      if (cmdTake) begin
        readQ <= pwdata[CMD_READ_BIT];
        chanQ <= pwdata[CMD_CHAN_LSB +: CHAN_W];
        regQ <= pwdata[CMD_REG_LSB +: REG_AW];
        wdataQ <= pwdata[CMD_WDATA_LSB +: DATA_W];
      end
    end
  end

  assign cyc.start = startQ;

  // ----------------------------------------------------------------
  // Device interrupt and ready sensing
  // ----------------------------------------------------------------
  wire strobeMode = (modeQ == MODE_STROBE);
  // Direction-line style: one active-low request on channel A, others ignored
  // Decode in the style the device is in now: the mode pin trails CTRL by one cycle,
  // and decoding from CTRL would see a false channel A edge at a style change
  wire pinStrobe = (bus_mode_sel == MODE_STROBE);
  wire [NUM_CHAN-1:0] irqAct = pinStrobe ? {chan_d_irq, chan_c_irq, chan_b_irq, chan_a_irq}
                                          : {3'b000, !chan_a_irq};
  logic [NUM_CHAN-1:0] irqPrevQ;
  logic txPrevQ;
  logic rxPrevQ;

  // Edge history; ready pins already carry the AND of all four channels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqPrevQ <= '0;
      txPrevQ <= 1'b1;
      rxPrevQ <= 1'b1;
    end else begin
      irqPrevQ <= irqAct;
      txPrevQ <= tx_ready_n;
      rxPrevQ <= rx_ready_n;
    end
  end

  // Events: cycle finished, interrupt rising, first channel turning ready (combined ready pin falling)
  assign evtSet[EV_DONE_BIT] = cyc.done;
  assign evtSet[EV_IRQ_LSB +: NUM_CHAN] = irqAct & ~irqPrevQ;
  assign evtSet[EV_TX_READY_N_BIT] = txPrevQ && !tx_ready_n;
  assign evtSet[EV_RX_READY_N_BIT] = rxPrevQ && !rx_ready_n;
  // Only bits seen by the read are cleared, so a later event is not lost
  assign evtClr = (rdAcc && hitEvent) ? rdSnapQ : '0;

  // ----------------------------------------------------------------
  // Read path: data is sampled in the setup cycle
  // ----------------------------------------------------------------
  wire [31:0] statusWord = {{(32 - ST_IRQ_LSB - NUM_CHAN){1'b0}}, irqAct, modeQ, rx_ready_n, tx_ready_n, busyAll};
  wire [31:0] ctrlWord = {30'h0, forceQ, modeQ};
  wire [31:0] cmdWord = {15'h0, readQ, 3'h0, chanQ, regQ, wdataQ};
  wire [31:0] rdMux = hitCtrl ? ctrlWord
                    : hitCmd ? cmdWord
                    : hitStatus ? statusWord
                    : hitRdata ? {24'h0, rdataQ}
                    : hitEvent ? {{(32 - EV_W){1'b0}}, evtStatus}
                    : hitMask ? {{(32 - EV_W){1'b0}}, evtMask}
                    : 32'h0;

  // Read data register and snapshot of the flags returned
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdataQ <= '0;
      rdSnapQ <= '0;
    end else if (setupPh) begin
      prdataQ <= rdMux;
      rdSnapQ <= evtStatus;
    end
  end

  assign prdata = prdataQ;

  // ----------------------------------------------------------------
  // Device pin drive
  // ----------------------------------------------------------------
  // Strobe style selects: one low at most, only during a cycle
  wire [NUM_CHAN-1:0] oneHotSel = NUM_CHAN'(1) << chanQ;
  wire [NUM_CHAN-1:0] strbSelN = cyc.inCycle ? ~oneHotSel : '1;
  // Direction-line style: A is the device select, B/C carry A3/A4, D high
  wire [NUM_CHAN-1:0] rwSelN = {1'b1, chanQ[1], chanQ[0], !cyc.strobeOn};
  wire [NUM_CHAN-1:0] selD = strobeMode ? strbSelN : rwSelN;
  // Read strobe unused and high in direction-line style
  wire rdD = !(strobeMode && cyc.strobeOn && readQ);
  // Write pin: strobe, or a level that is high for read and low for write
  wire wrD = strobeMode ? !(cyc.strobeOn && !readQ) : (!cyc.inCycle || readQ);
  wire oeD = cyc.inCycle && !readQ;
  // Force input only driven in strobe style, low otherwise
  wire forceD = strobeMode && forceQ;

  // Registered pins; address and data stay valid through setup and hold
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_mode_sel <= MODE_RWLINE;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      {chan_d_select_n, chan_c_select_n, chan_b_select_n, chan_a_select_n} <= '1;
      reg_addr <= '0;
      data_out <= '0;
      data_oe <= 1'b0;
      irq_force_enable <= 1'b0;
    end else begin
      bus_mode_sel <= modeQ;
      read_strobe_n <= rdD;
      write_strobe_n <= wrD;
      {chan_d_select_n, chan_c_select_n, chan_b_select_n, chan_a_select_n} <= selD;
      reg_addr <= regQ;
      data_out <= wdataQ;
      data_oe <= oeD;
      irq_force_enable <= forceD;
    end
  end

  // Read byte taken at the edge where the strobe (or select) rises
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdataQ <= '0;
    end else if (cyc.capture && readQ) begin
      rdataQ <= data_in;
    end
  end

endmodule

// file: tb/qhp_uart_model.sv
// Behavioural quad UART device as seen from its parallel host port
`timescale 1ns/1ps
module qhp_uart_model (
  input wire logic bus_mode_sel,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  input wire logic chan_c_select_n,
  input wire logic chan_d_select_n,
  input wire logic [qhp_pkg::REG_AW-1:0] reg_addr,
  input wire logic [qhp_pkg::DATA_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic irq_force_enable,
  input wire logic [3:0] irqReq,
  input wire logic [3:0] txN,
  input wire logic [3:0] rxN,
  output logic [qhp_pkg::DATA_W-1:0] data_in,
  output logic chan_a_irq,
  output logic chan_b_irq,
  output logic chan_c_irq,
  output logic chan_d_irq,
  output logic tx_ready_n,
  output logic rx_ready_n
);
  import qhp_pkg::*;
  logic [7:0] regs [4][8];
  logic [7:0] lastQ;
  logic [3:0] sel;
  logic [3:0] en;
  logic [1:0] chan;
  logic drive;
  initial begin
    lastQ = 8'h00;
    for (int i = 0; i < 32; i++) regs[i / 8][i % 8] = 8'h00;
  end
  // ----
  // Channel decode and read drive
  // ----
  assign sel = ~{chan_d_select_n, chan_c_select_n, chan_b_select_n, chan_a_select_n};
  assign chan = bus_mode_sel ? {sel[3] | sel[2], sel[3] | sel[1]} : {chan_c_select_n, chan_b_select_n};
  assign drive = bus_mode_sel ? !read_strobe_n && |sel : !chan_a_select_n && write_strobe_n;
  // A released bus shows the inverse of its last value, so a stale capture is caught
  assign data_in = drive ? regs[chan][reg_addr] : ~lastQ;
  always @* if (drive) lastQ = regs[chan][reg_addr];
  // Writes land on the rising write strobe, or on the rising device select
  always @(posedge write_strobe_n)
    if (bus_mode_sel && |sel && data_oe) regs[chan][reg_addr] = data_out;
  always @(posedge chan_a_select_n)
    if (!bus_mode_sel && !write_strobe_n && data_oe) regs[chan][reg_addr] = data_out;
  // Interrupt pins: an undriven pin reads low, the open-drain one is pulled up
  assign en = {4{irq_force_enable}} | {regs[3][4][3], regs[2][4][3], regs[1][4][3], regs[0][4][3]};
  assign chan_a_irq = bus_mode_sel ? en[0] & irqReq[0] : ~|irqReq;
  assign chan_b_irq = bus_mode_sel & en[1] & irqReq[1];
  assign chan_c_irq = bus_mode_sel & en[2] & irqReq[2];
  assign chan_d_irq = bus_mode_sel & en[3] & irqReq[3];
  assign tx_ready_n = &txN;
  assign rx_ready_n = &rxN;
endmodule

// file: tb/qhp_host_port_properties.sv
// Pin protocol checker for the quad UART host port
`timescale 1ns/1ps
module qhp_chk
  import qhp_pkg::*;
#(
  parameter int STROBE_N = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic bus_mode_sel,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  input wire logic chan_c_select_n,
  input wire logic chan_d_select_n,
  input wire logic [qhp_pkg::REG_AW-1:0] reg_addr,
  input wire logic [qhp_pkg::DATA_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic irq_force_enable
);
  logic strobeOn;
  logic [7:0] lowCnt_q;
  // Strobe phase is the strobe pins in one style, the device select in the other
  assign strobeOn = bus_mode_sel ? !(read_strobe_n && write_strobe_n) : !chan_a_select_n;
  always_ff @(posedge clk or posedge rst)
    if (rst) lowCnt_q <= 8'h00;
    else lowCnt_q <= strobeOn ? lowCnt_q + 8'h01 : 8'h00;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  strobe_width_a: assert property ($fell(strobeOn) |-> lowCnt_q == STROBE_N)
    else $error("strobe width wrong");
  one_select_a: assert property (bus_mode_sel && strobeOn |->
    $countones({chan_a_select_n, chan_b_select_n, chan_c_select_n, chan_d_select_n}) == 3)
    else $error("not exactly one select");
  read_idle_a: assert property (!bus_mode_sel |-> read_strobe_n)
    else $error("read strobe used");
  chan_d_idle_a: assert property (!bus_mode_sel |-> chan_d_select_n)
    else $error("channel D select low");
  force_low_a: assert property (!bus_mode_sel [*3] |-> !irq_force_enable)
    else $error("force high");
  read_float_a: assert property (bus_mode_sel && !read_strobe_n |-> !data_oe)
    else $error("bus driven on read");
  write_data_a: assert property (bus_mode_sel && !write_strobe_n |-> data_oe && $stable(data_out))
    else $error("write data not held");
  dir_line_a: assert property (!bus_mode_sel && !chan_a_select_n |-> write_strobe_n != data_oe)
    else $error("direction wrong");
  chan_addr_a: assert property (!bus_mode_sel && !chan_a_select_n |->
    $stable({chan_b_select_n, chan_c_select_n, reg_addr})) else $error("address moved");
  cover property (bus_mode_sel && !write_strobe_n);
  cover property (bus_mode_sel && !read_strobe_n);
  cover property (!bus_mode_sel && !chan_a_select_n && !write_strobe_n);
endmodule
bind qhp_host_port qhp_chk #(.STROBE_N(STROBE_N)) i_qhp_chk (.*);

// file: tb/qhp_host_port_tb.sv
// Self-checking bench for the quad UART host port
`timescale 1ns/1ps
module qhp_host_port_tb;
  import qhp_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, lastErr;
  logic [7:0] paddr, data_out, data_in;
  logic [31:0] pwdata, prdata, rv;
  logic bus_mode_sel, read_strobe_n, write_strobe_n, data_oe, irq_force_enable;
  logic chan_a_select_n, chan_b_select_n, chan_c_select_n, chan_d_select_n;
  logic chan_a_irq, chan_b_irq, chan_c_irq, chan_d_irq, tx_ready_n, rx_ready_n;
  logic [2:0] reg_addr;
  logic [3:0] irqReq, txN, rxN;
  int n_mismatch = 0;
  int checks_done = 0;
  qhp_host_port i_qhp_host_port (.*);
  qhp_uart_model i_qhp_uart_model (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----
  // Reporting and bus tasks
  // ----
  task automatic close_out;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Held until pready is seen high; an idle cycle follows so psel is never set twice at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      close_out();
    end
    rv = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // One device cycle: command, wait for busy to drop, fetch the read byte
  task automatic dev(input logic r, input logic [1:0] c, input logic [2:0] g, input logic [7:0] d);
    int n;
    apb(1'b1, OFS_CMD, {15'h0, r, 3'h0, c, g, d});
    n = 0;
    do begin
      rd(OFS_STATUS);
      n++;
    end while (rv[ST_BUSY_BIT] !== 1'b0 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      close_out();
    end
    rd(OFS_RDATA);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    rd(OFS_CTRL);
    chk(rv, 32'h0, "ctrl reset");
    rd(OFS_EVENT);
    chk(rv, 32'h0, "event reset");
    rd(OFS_MASK);
    chk(rv, 32'h0, "mask reset");
    rd(8'h18);
    chk({rv[31:1], lastErr}, 32'h1, "unmapped");
  endtask
  // Every channel, a distinct register each, written then read back
  task automatic sweep(input logic m, input logic [7:0] base);
    logic [2:0] g;
    apb(1'b1, OFS_CTRL, {31'h0, m});
    for (int c = 0; c < 4; c++) begin
      g = 3'(c * 2 + 32'(m));
      dev(1'b0, 2'(c), g, base + 8'(c));
      chk(i_qhp_uart_model.regs[c][g], base + 8'(c), "stored byte");
      chk(i_qhp_uart_model.regs[(c + 1) % 4][g], 32'h0, "other channel");
      dev(1'b1, 2'(c), g, 8'h00);
      chk(rv[7:0], base + 8'(c), "read byte");
    end
  endtask
  task automatic t_irq;
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_MASK, 32'h4);
    rd(OFS_EVENT);
    irqReq <= 4'b0010;
    rd(OFS_STATUS);
    rd(OFS_EVENT);
    chk(rv[2], 32'h0, "pin off when disabled");
    dev(1'b0, 2'h1, 3'h4, 8'h08);
    chk(irq, 32'h1, "irq raised");
    rd(OFS_EVENT);
    chk(rv[2], 32'h1, "event set");
    chk(irq, 32'h0, "irq cleared by read");
    apb(1'b1, OFS_MASK, 32'h0);
    irqReq <= 4'b0100;
    rd(OFS_STATUS);
    rd(OFS_STATUS);
    chk(rv[6], 32'h0, "channel C disabled");
    apb(1'b1, OFS_CTRL, 32'h3);
    rd(OFS_STATUS);
    rd(OFS_STATUS);
    chk(rv[6], 32'h1, "forced enable");
    chk(irq, 32'h0, "masked"); 
    irqReq <= 4'b0000;
  endtask
  task automatic t_dir_irq;
    apb(1'b1, OFS_CTRL, 32'h0);
    rd(OFS_EVENT);
    chk(rv[1], 32'h0, "no false edge on style change");
    irqReq <= 4'b1000;
    rd(OFS_STATUS);
    rd(OFS_STATUS);
    chk(rv[7:4], 32'h1, "combined request");
    irqReq <= 4'b0000;
    rd(OFS_STATUS);
    rd(OFS_STATUS);
    chk(rv[7:4], 32'h0, "request released");
  endtask
  task automatic t_ready;
    txN <= 4'b1011;
    rd(OFS_STATUS);
    rd(OFS_STATUS);
    chk(rv[2:1], 32'h2, "tx ready");
    txN <= 4'b1111;
    rxN <= 4'b0111;
    rd(OFS_STATUS);
    rd(OFS_STATUS);
    chk(rv[2:1], 32'h1, "rx ready");
    rd(OFS_EVENT);
    chk(rv[6:5], 32'h3, "ready events");
  endtask
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    irqReq = 4'h0;
    txN = 4'hF;
    rxN = 4'hF;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    sweep(1'b1, 8'hA0);
    sweep(1'b0, 8'h50);
    t_irq();
    t_dir_irq();
    t_ready();
    close_out();
  end
endmodule
